// ==== mem_map_pkg.sv ====
// Constants and types shared by the memory space address mapper
package mem_map_pkg;

    // ==========================================================
    // Address spaces seen by the requester
    typedef enum logic [1:0] {
        SPACE_CODE,
        SPACE_DATA,
        SPACE_XDATA,
        SPACE_SFR
    } space_t;

    // ==========================================================
    // XDATA / unified CODE window boundaries
    localparam logic [15:0] XD_RADIO_BASE = 16'hdf00;
    localparam logic [15:0] XD_SFR_BASE = 16'hdf80;
    localparam logic [15:0] XD_SRAM_BASE = 16'he000;
    localparam logic [15:0] XD_RET_BASE = 16'hf000;
    localparam logic [15:0] XD_NORET_LO = 16'hfd56;
    localparam logic [15:0] XD_NORET_HI = 16'hfeff;

    // DATA space sits in the top 256 bytes of the 8 KB SRAM
    localparam logic [12:0] DATA_SRAM_BASE = 13'h1f00;
    // Bit-addressable bytes of the lower DATA area
    localparam logic [7:0] DATA_BIT_BASE = 8'h20;

    // ==========================================================
    // Bank select storage, reached at two SFR locations
    localparam logic [7:0] SFR_BANK_ADDR = 8'h9f;
    localparam logic [7:0] SFR_MEMCTL_ADDR = 8'hc7;
    localparam int BANK_LSB = 0;
    localparam int MIRROR_LSB = 4;
    localparam int UNIFIED_POS = 6;
    localparam logic [1:0] BANK_RESET = 2'h0;
    localparam logic UNIFIED_RESET = 1'b0;

    // ==========================================================
    // Complete registered state of the mapper
    typedef struct packed {
        logic unified;
        logic [1:0] bank;
        logic flash_sel;
        logic sram_sel;
        logic radio_sel;
        logic sfr_sel;
        logic [16:0] flash_addr;
        logic [12:0] sram_addr;
        logic [7:0] reg_addr;
        logic [2:0] bit_sel;
        logic bit_op;
        logic wr;
        logic [7:0] wdata;
        logic stall;
        logic retained;
        logic low_half_on;
        logic ctrl_hit;
        logic [7:0] ctrl_rdata;
    } state_t;

endpackage : mem_map_pkg

// ==== mem_space_mapper.sv ====
// Memory space address mapper: CODE, DATA, XDATA and SFR onto flash, SRAM and registers
// Functional notes
// - CODE is 64 KB read-only; writes through CODE never reach any memory.
// - DATA spans 256 bytes; upper half only by indirect access.
// - XDATA spans 64 KB; prefetch stalls while an XDATA access is running.
// - SFR space has 128 byte registers; multiples of eight are bit addressable.
// - After reset CODE uses the standard, flash-only mapping.
// - Unified bit set maps all memories into CODE like XDATA; clear maps flash only.
// - Above 32 KB flash, XDATA 0x0000-0xDEFF reaches the first 56 KB of flash.
// - With 32 KB flash, XDATA 0x0000-0x7FFF is flash; above is undefined.
// - XDATA 0xE000-0xFFFF reaches the 8 KB SRAM on every flash option.
// - XDATA 0xDF80-0xDFFF reaches the SFR registers outside the core on every option.
// - XDATA 0xDF00-0xDF7F reaches the radio registers on every option.
// - Bank selection never changes what XDATA sees in flash.
// - In power modes two and three, 0xF000-0xFFFF keeps data except a hole.
// - Core-internal registers are unreachable through unified CODE.
// - Unified CODE maps 56 KB flash, upper 24 KB banked; above 0xDEFF no flash.
// - Unified CODE shows the SRAM so code can run from it.
// - 128 KB option: upper 32 KB CODE follows the bank, lower 32 KB fixed.
// - Bank select is one store seen at two register locations.
// - Banked unified CODE reaches only the lower 24 KB of the bank.
// - DATA is the top 256 SRAM bytes, also at 0xFF00-0xFFFF in XDATA/CODE.
// - Core-internal registers are reachable only through SFR space and direct or bit-addressed DATA access.
`timescale 1ns/1ns
module mem_space_mapper
    import mem_map_pkg::*;
#(
    parameter int FLASH_KB = 128
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic req_valid,
    input wire space_t req_space,
    input wire logic [15:0] req_addr,
    input wire logic req_write,
    input wire logic [7:0] req_wdata,
    input wire logic req_direct,
    input wire logic req_bit,
    input wire logic power_mode_two,
    input wire logic power_mode_three,
    output logic flash_sel,
    output logic [16:0] flash_addr,
    output logic sram_sel,
    output logic [12:0] sram_addr,
    output logic radio_sel,
    output logic sfr_sel,
    output logic [7:0] reg_addr,
    output logic bit_op,
    output logic [2:0] bit_sel,
    output logic mem_write,
    output logic [7:0] mem_wdata,
    output logic prefetch_stall,
    output logic sram_retained,
    output logic sram_low_half_on,
    output logic ctrl_hit,
    output logic [7:0] ctrl_rdata,
    output logic unified_code_map_bit,
    output logic [1:0] code_bank_select
);

    // ==========================================================
    // Decoding helpers

    // Flash target of a 16-bit address: {hit, physical address}
    function automatic logic [17:0] flash_map(input logic [15:0] a, input logic [1:0] bk,
                                              input logic code);
        logic [17:0] r;
        r = 18'h0_0000;
        if (!a[15]) begin
            r = {1'b1, 2'b00, a[14:0]};
        end else if (FLASH_KB > 32) begin
            if (code && FLASH_KB > 64) begin
                r = {1'b1, bk, a[14:0]};
            end else begin
                r = {1'b1, 1'b0, a};
            end
        end
        return r;
    endfunction : flash_map

    // Registers that live inside the CPU core
    function automatic logic is_core_sfr(input logic [7:0] r);
        logic hit;
        hit = 1'b0;
        unique case (r)
            8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h87, 8'h92: hit = 1'b1;
            8'ha8, 8'ha9, 8'hb8, 8'hb9, 8'hd0, 8'he0, 8'hf0: hit = 1'b1;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction : is_core_sfr

    // ==========================================================
    // State

    state_t s_reg;
    state_t s_next;
    logic [17:0] fm;
    logic xd_path;
    logic [15:0] xa;

    always_comb begin
        s_next = s_reg;
        s_next.flash_sel = 1'b0;
        s_next.sram_sel = 1'b0;
        s_next.radio_sel = 1'b0;
        s_next.sfr_sel = 1'b0;
        s_next.bit_op = 1'b0;
        s_next.bit_sel = 3'h0;
        s_next.flash_addr = 17'h0_0000;
        s_next.sram_addr = 13'h0000;
        s_next.reg_addr = 8'h00;
        s_next.wdata = req_wdata;
        s_next.ctrl_hit = 1'b0;
        s_next.ctrl_rdata = 8'h00;
        s_next.stall = req_valid && req_space == SPACE_XDATA;
        s_next.low_half_on = !(power_mode_two || power_mode_three);
        fm = flash_map(req_addr, s_reg.bank, req_space == SPACE_CODE);
        xd_path = req_space == SPACE_XDATA || (req_space == SPACE_CODE && s_reg.unified);
        xa = 16'h0000;
        if (req_valid) begin
            if (xd_path) begin
                if (req_addr >= XD_SRAM_BASE) begin
                    s_next.sram_sel = 1'b1;
                    s_next.sram_addr = req_addr[12:0];
                end else if (req_addr >= XD_SFR_BASE) begin
                    s_next.reg_addr = {1'b1, req_addr[6:0]};
                    s_next.sfr_sel = !is_core_sfr({1'b1, req_addr[6:0]});
                end else if (req_addr >= XD_RADIO_BASE) begin
                    s_next.radio_sel = 1'b1;
                    s_next.reg_addr = {1'b0, req_addr[6:0]};
                end else begin
                    s_next.flash_sel = fm[17];
                    s_next.flash_addr = fm[16:0];
                end
            end else if (req_space == SPACE_CODE) begin
                s_next.flash_sel = fm[17];
                s_next.flash_addr = fm[16:0];
            end else if (req_space == SPACE_DATA) begin
                if (req_bit) begin
                    s_next.bit_op = 1'b1;
                    s_next.bit_sel = req_addr[2:0];
                    if (req_addr[7]) begin
                        s_next.sfr_sel = 1'b1;
                        s_next.reg_addr = {req_addr[7:3], 3'b000};
                    end else begin
                        s_next.sram_sel = 1'b1;
                        s_next.sram_addr = DATA_SRAM_BASE | {9'h000, 4'h0} |
                            {5'h00, DATA_BIT_BASE + {4'h0, req_addr[6:3]}};
                    end
                end else if (req_direct && req_addr[7]) begin
                    s_next.sfr_sel = 1'b1;
                    s_next.reg_addr = req_addr[7:0];
                end else begin
                    s_next.sram_sel = 1'b1;
                    s_next.sram_addr = DATA_SRAM_BASE | {5'h00, req_addr[7:0]};
                end
            end else begin
                s_next.sfr_sel = req_addr[7];
                s_next.bit_op = req_bit && req_addr[7];
                s_next.bit_sel = req_bit ? req_addr[2:0] : 3'h0;
                s_next.reg_addr = req_bit ? {req_addr[7:3], 3'b000} : req_addr[7:0];
            end
        end
        // Flash programming is elsewhere; CODE is never written
        // A write with no writable target selected is dropped, not strobed
        s_next.wr = req_valid && req_write && req_space != SPACE_CODE &&
                    (s_next.sram_sel || s_next.sfr_sel || s_next.radio_sel);
        xa = {3'b111, s_next.sram_addr};
        s_next.retained = s_next.sram_sel && xa >= XD_RET_BASE &&
                          !(xa >= XD_NORET_LO && xa <= XD_NORET_HI);
        // Bank select store, shared by both register locations
        if (s_next.sfr_sel && !s_next.bit_op) begin
            if (s_next.reg_addr == SFR_BANK_ADDR) begin
                s_next.ctrl_hit = 1'b1;
                s_next.ctrl_rdata = {6'h00, s_reg.bank};
                if (s_next.wr) begin
                    s_next.bank = req_wdata[BANK_LSB +: 2];
                end
            end else if (s_next.reg_addr == SFR_MEMCTL_ADDR) begin
                s_next.ctrl_hit = 1'b1;
                s_next.ctrl_rdata = {1'b0, s_reg.unified, s_reg.bank, 4'h0};
                if (s_next.wr) begin
                    s_next.bank = req_wdata[MIRROR_LSB +: 2];
                    s_next.unified = req_wdata[UNIFIED_POS];
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '0;
            s_reg.bank <= BANK_RESET;
            s_reg.unified <= UNIFIED_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // ==========================================================
    // Outputs

    assign flash_sel = s_reg.flash_sel;
    assign flash_addr = s_reg.flash_addr;
    assign sram_sel = s_reg.sram_sel;
    assign sram_addr = s_reg.sram_addr;
    assign radio_sel = s_reg.radio_sel;
    assign sfr_sel = s_reg.sfr_sel;
    assign reg_addr = s_reg.reg_addr;
    assign bit_op = s_reg.bit_op;
    assign bit_sel = s_reg.bit_sel;
    assign mem_write = s_reg.wr;
    assign mem_wdata = s_reg.wdata;
    assign prefetch_stall = s_reg.stall;
    assign sram_retained = s_reg.retained;
    assign sram_low_half_on = s_reg.low_half_on;
    assign ctrl_hit = s_reg.ctrl_hit;
    assign ctrl_rdata = s_reg.ctrl_rdata;
    assign unified_code_map_bit = s_reg.unified;
    assign code_bank_select = s_reg.bank;

    // ==========================================================
    // Assertions

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    code_no_write_a: assert property (
        req_valid && req_space == SPACE_CODE |=> !mem_write)
        else $error("write reached memory through CODE");

    data_to_sram_a: assert property (
        req_valid && req_space == SPACE_DATA && !req_bit && !(req_direct && req_addr[7])
        |=> sram_sel && sram_addr == (DATA_SRAM_BASE | {5'h00, $past(req_addr[7:0])}))
        else $error("DATA access not at top of SRAM");

    xdata_stall_a: assert property (
        req_valid && req_space == SPACE_XDATA |=> prefetch_stall)
        else $error("prefetch not stalled during XDATA");

    std_code_flash_a: assert property (
        req_valid && req_space == SPACE_CODE && !unified_code_map_bit
        |=> !sram_sel && !sfr_sel && !radio_sel)
        else $error("standard CODE left flash");

    xd_sram_map_a: assert property (
        req_valid && xd_path && req_addr >= XD_SRAM_BASE
        |=> sram_sel && sram_addr == $past(req_addr[12:0]) && !flash_sel)
        else $error("SRAM window misdecoded");

    xd_core_sfr_a: assert property (
        req_valid && xd_path && req_addr[15:7] == 9'h1bf && is_core_sfr({1'b1, req_addr[6:0]})
        |=> !sfr_sel)
        else $error("core register reached outside SFR space");

    xd_radio_map_a: assert property (
        req_valid && xd_path && req_addr[15:7] == 9'h1be
        |=> radio_sel && reg_addr == {1'b0, $past(req_addr[6:0])})
        else $error("radio window misdecoded");

    xd_flash_fixed_a: assert property (
        req_valid && req_space == SPACE_XDATA && req_addr < XD_RADIO_BASE && FLASH_KB > 32
        |=> flash_sel && flash_addr == {1'b0, $past(req_addr)})
        else $error("XDATA flash view moved");

    unified_top_a: assert property (
        req_valid && xd_path && req_addr >= XD_RADIO_BASE |=> !flash_sel)
        else $error("flash data above 0xDEFF");

    bank_mirror_a: assert property (
        req_valid && req_write && req_space == SPACE_SFR && !req_bit &&
        req_addr[7:0] == SFR_MEMCTL_ADDR
        |=> code_bank_select == $past(req_wdata[MIRROR_LSB +: 2]) ##1
            (code_bank_select == $past(code_bank_select) || $past(req_valid)))
        else $error("bank mirror not shared");

endmodule : mem_space_mapper

// ==== core_requester.sv ====
// Requester model standing in for the CPU core and DMA controller
`timescale 1ns/1ns
module core_requester
    import mem_map_pkg::*;
(
    input wire logic core_clk,
    output logic req_valid,
    output space_t req_space,
    output logic [15:0] req_addr,
    output logic req_write,
    output logic [7:0] req_wdata,
    output logic req_direct,
    output logic req_bit
);
    initial begin
        req_valid = 1'b0;
        req_space = SPACE_CODE;
        req_addr = 16'h0000;
        req_write = 1'b0;
        req_wdata = 8'h00;
        req_direct = 1'b0;
        req_bit = 1'b0;
    end

    // ==========================================================
    // One request per call; released lines show inverted data so stale values never match
    task automatic issue(input space_t s, input logic [15:0] a, input logic w = 1'b0,
                         input logic [7:0] d = 8'h00, input logic dr = 1'b0,
                         input logic b = 1'b0);
        @(posedge core_clk);
        req_valid <= 1'b1;
        req_space <= s;
        req_addr <= a;
        req_write <= w;
        req_wdata <= d;
        req_direct <= dr;
        req_bit <= b;
        @(posedge core_clk);
        req_valid <= 1'b0;
        req_write <= 1'b0;
        req_addr <= ~a;
        req_wdata <= ~d;
        #1;
    endtask : issue
endmodule : core_requester

// ==== memory_space_address_mapper_tb.sv ====
// Self-checking testbench for the memory space address mapper
`timescale 1ns/1ns
module memory_space_address_mapper_tb;
    import mem_map_pkg::*;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic power_mode_two = 1'b0;
    logic power_mode_three = 1'b0;
    logic req_valid, req_write, req_direct, req_bit;
    space_t req_space;
    logic [15:0] req_addr;
    logic [7:0] req_wdata, reg_addr, mem_wdata, ctrl_rdata;
    logic flash_sel, sram_sel, radio_sel, sfr_sel, bit_op, mem_write, prefetch_stall;
    logic sram_retained, sram_low_half_on, ctrl_hit, unified_code_map_bit;
    logic [16:0] flash_addr;
    logic [12:0] sram_addr;
    logic [2:0] bit_sel;
    logic [1:0] code_bank_select;
    int checks = 0;
    int bad_count = 0;
    int cycles = 0;

    always #20 core_clk = ~core_clk;

    mem_space_mapper #(.FLASH_KB(128)) dut_u (.core_clk, .nrst, .req_valid, .req_space,
        .req_addr, .req_write, .req_wdata, .req_direct, .req_bit, .power_mode_two,
        .power_mode_three, .flash_sel, .flash_addr, .sram_sel, .sram_addr, .radio_sel,
        .sfr_sel, .reg_addr, .bit_op, .bit_sel, .mem_write, .mem_wdata, .prefetch_stall,
        .sram_retained, .sram_low_half_on, .ctrl_hit, .ctrl_rdata, .unified_code_map_bit,
        .code_bank_select);

    core_requester req_u (.core_clk, .req_valid, .req_space, .req_addr, .req_write,
        .req_wdata, .req_direct, .req_bit);

    // ==========================================================
    // Reporting
    task automatic chk(input string name, input logic [16:0] exp, input logic [16:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic finish_test();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            finish_test();
        end
    end

    // ==========================================================
    // Scenarios
    task automatic reset_defaults();
        chk("unified", 0, unified_code_map_bit);
        chk("bank", 0, code_bank_select);
        req_u.issue(SPACE_CODE, 16'he010);
        chk("sram_sel", 0, sram_sel);
        chk("flash_addr", 17'h06010, flash_addr);
    endtask : reset_defaults

    task automatic xdata_windows();
        req_u.issue(SPACE_XDATA, 16'he123, 1'b1, 8'h5a);
        chk("sram_addr", 17'h10123, {sram_sel, 3'h0, sram_addr});
        chk("write", {mem_write, mem_wdata}, 9'h15a);
        chk("stall", 1, prefetch_stall);
        req_u.issue(SPACE_XDATA, 16'hdfa0);
        chk("sfr", {sfr_sel, reg_addr}, 9'h1a0);
        req_u.issue(SPACE_XDATA, 16'hdf10);
        chk("radio", {radio_sel, reg_addr[6:0]}, 8'h90);
        req_u.issue(SPACE_XDATA, 16'hdf81);
        chk("core_sfr", 0, sfr_sel);
        req_u.issue(SPACE_XDATA, 16'hfe00);
        chk("hole", 0, sram_retained);
        req_u.issue(SPACE_XDATA, 16'hf100);
        chk("retained", 1, sram_retained);
        req_u.issue(SPACE_XDATA, 16'hdd00);
        chk("flash_sel", 1, flash_sel);
        chk("flash", 17'h0dd00, flash_addr);
    endtask : xdata_windows

    task automatic code_write();
        req_u.issue(SPACE_CODE, 16'h1234, 1'b1, 8'haa);
        chk("code_wr", 0, mem_write);
        chk("flash_addr", 17'h01234, flash_addr);
        chk("no_stall", 0, prefetch_stall);
    endtask : code_write

    task automatic banking();
        req_u.issue(SPACE_SFR, 16'h009f, 1'b1, 8'h02);
        chk("bank", 2, code_bank_select);
        chk("ctrl_hit", 1, ctrl_hit);
        req_u.issue(SPACE_SFR, 16'h00c7);
        chk("mirror", 8'h20, ctrl_rdata);
        req_u.issue(SPACE_CODE, 16'h9000);
        chk("upper", 17'h11000, flash_addr);
        req_u.issue(SPACE_CODE, 16'h1000);
        chk("lower", 17'h01000, flash_addr);
        req_u.issue(SPACE_XDATA, 16'h9000);
        chk("xdata", 17'h09000, flash_addr);
        req_u.issue(SPACE_SFR, 16'h00c7, 1'b1, 8'h30);
        chk("bank", 3, code_bank_select);
    endtask : banking

    task automatic unified_code();
        req_u.issue(SPACE_SFR, 16'h00c7, 1'b1, 8'h60);
        chk("unified", {unified_code_map_bit, code_bank_select}, 3'h6);
        req_u.issue(SPACE_CODE, 16'he010);
        chk("sram", 17'h10010, {sram_sel, 3'h0, sram_addr});
        req_u.issue(SPACE_CODE, 16'hdfa0);
        chk("sfr", 1, sfr_sel);
        req_u.issue(SPACE_CODE, 16'hdf81);
        chk("core_sfr", 0, sfr_sel);
        req_u.issue(SPACE_CODE, 16'ha000);
        chk("banked", 17'h12000, flash_addr);
        req_u.issue(SPACE_CODE, 16'hdf10);
        chk("no_flash", 0, flash_sel);
        req_u.issue(SPACE_CODE, 16'hff20);
        chk("data_alias", 13'h1f20, sram_addr);
    endtask : unified_code

    task automatic data_sfr_space();
        req_u.issue(SPACE_DATA, 16'h0030, 1'b0, 8'h00, 1'b1);
        chk("direct", 13'h1f30, sram_addr);
        req_u.issue(SPACE_DATA, 16'h00c0);
        chk("indirect", {sram_sel, 3'h0, sram_addr}, 17'h11fc0);
        req_u.issue(SPACE_DATA, 16'h00c0, 1'b0, 8'h00, 1'b1);
        chk("direct_hi", {sram_sel, sfr_sel}, 2'h1);
        req_u.issue(SPACE_SFR, 16'h008b, 1'b0, 8'h00, 1'b0, 1'b1);
        chk("bit", {bit_op, bit_sel, reg_addr}, 12'hb88);
        req_u.issue(SPACE_SFR, 16'h0040, 1'b1, 8'h11);
        chk("unmapped", {sfr_sel, sram_sel, flash_sel, mem_write}, 4'h0);
    endtask : data_sfr_space

    task automatic power_modes();
        @(posedge core_clk);
        power_mode_two <= 1'b1;
        @(posedge core_clk);
        #1;
        chk("low_half", 0, sram_low_half_on);
        power_mode_two <= 1'b0;
        power_mode_three <= 1'b1;
        @(posedge core_clk);
        #1;
        chk("low_half", 0, sram_low_half_on);
        @(posedge core_clk);
        power_mode_three <= 1'b0;
        @(posedge core_clk);
        @(posedge core_clk);
        #1;
        chk("low_half_on", 1, sram_low_half_on);
    endtask : power_modes

    initial begin
        repeat (5) @(posedge core_clk);
        nrst <= 1'b1;
        #1;
        reset_defaults();
        xdata_windows();
        code_write();
        banking();
        unified_code();
        data_sfr_space();
        power_modes();
        finish_test();
    end
endmodule : memory_space_address_mapper_tb
